// ### pin_mux_pkg.sv
// shared constants and types for the pin routing matrix, plus the pin input synchroniser
// Contract
// - a pin configured as input feeds its level to both listed block inputs
// - pin with port output and serial transmit drives the AND of both
// - slave data-out driver enabled only while slave chip-select is active
// - competing functions win by fixed priority: oscillator, master, slave, pwm, analog, two-wire
// - programming-port functions reach their pins only while programming mode is high
// - select 000 connects a crystal across P0.0 and P0.1, taking both pins
// - select 011 takes a low-amplitude low-frequency clock from P0.1
// - select 100 takes a digital low-frequency clock input
`timescale 1ns/100ps
`default_nettype none

package pin_mux_pkg;
	localparam int NUM_PINS = 15;
	localparam int NUM_ANALOG = 11;
	localparam int NUM_PRI = 7;

	// pin index: P0.n is n, P1.n is 8 + n; analog input k sits on pin k
	localparam int PIN_XTAL_A = 0;
	localparam int PIN_LF_CLOCK = 1;
	localparam int PIN_PULSE_WIDTH_OUTPUT_0 = 2;
	localparam int PIN_PULSE_WIDTH_OUTPUT_1_TX = 3;
	localparam int PIN_RX_TW_CLOCK = 4;
	localparam int PIN_SCK_TW_DATA = 5;
	localparam int PIN_PIN_INTERRUPT_INPUT_1 = 6;
	localparam int PIN_SLAVE_IN = 7;
	localparam int PIN_SLAVE_OUT = 8;
	localparam int PIN_CHIP_SELECT = 9;
	localparam int PIN_MASTER_CLOCK = 12;
	localparam int PIN_MASTER_OUT = 13;
	localparam int PIN_MASTER_IN = 14;

	// request bit positions, lowest number wins except PRI_PORT, which wins only when no other bit is set
	localparam int PRI_PORT = 0;
	localparam int PRI_LF_OSC = 1;
	localparam int PRI_MASTER = 2;
	localparam int PRI_SLAVE = 3;
	localparam int PRI_PWM = 4;
	localparam int PRI_ANALOG = 5;
	localparam int PRI_TWO_WIRE = 6;

	localparam logic [2:0] LF_SEL_CRYSTAL = 3'h0;
	localparam logic [2:0] LF_SEL_LOW_AMP = 3'h3;
	localparam logic [2:0] LF_SEL_DIGITAL = 3'h4;

	localparam logic [NUM_PINS-1:0] PIN_OUT_RESET = 15'h0000;
	localparam logic [NUM_PINS-1:0] PIN_OE_RESET = 15'h0000;
	localparam logic [NUM_PINS-1:0] PORT_IN_RESET = 15'h0000;
	localparam logic [NUM_ANALOG-1:0] ANALOG_RESET = 11'h000;
	localparam logic SYNC_RESET = 1'b0;

	typedef enum logic [2:0] {
		OWN_PORT = 3'b000,
		OWN_LF_OSC = 3'b001,
		OWN_MASTER = 3'b010,
		OWN_SLAVE = 3'b011,
		OWN_PWM = 3'b100,
		OWN_ANALOG = 3'b101,
		OWN_TWO_WIRE = 3'b111
	} owner_t;

	typedef struct packed {
		logic master_enable;
		logic slave_enable;
		logic pulse_width_output_0_enable;
		logic pulse_width_output_1_enable;
		logic two_wire_enable;
		logic uart_tx_enable;
		logic [NUM_ANALOG-1:0] analog_enable;
		logic [2:0] low_freq_clock_source_select;
	} cfg_t;

	typedef struct packed {
		logic master_data_out;
		logic master_serial_clock;
		logic slave_data_out;
		logic programming_mode_input_port_data_out;
		logic pulse_width_output_0;
		logic pulse_width_output_1;
		logic uart_tx;
		logic two_wire_data_drive_low;
		logic two_wire_clock_drive_low;
	} periph_to_pins_t;

	typedef struct packed {
		logic master_data_in;
		logic slave_chip_select_n;
		logic slave_serial_clock;
		logic slave_data_in;
		logic programming_mode_input_port_chip_select_n;
		logic programming_mode_input_port_serial_clock;
		logic programming_mode_input_port_data_in;
		logic timer0_count_input;
		logic timer1_count_input;
		logic pin_interrupt_input_0;
		logic pin_interrupt_input_1;
		logic uart_rx;
		logic two_wire_data_in;
		logic two_wire_clock_in;
		logic low_freq_clock;
	} pins_to_periph_t;

	// idle levels: chip selects, receive line and two-wire lines rest high
	localparam pins_to_periph_t TO_PERIPH_RESET = '{
		slave_chip_select_n: 1'b1,
		programming_mode_input_port_chip_select_n: 1'b1,
		uart_rx: 1'b1,
		two_wire_data_in: 1'b1,
		two_wire_clock_in: 1'b1,
		default: 1'b0
	};
endpackage : pin_mux_pkg

module input_sync
	import pin_mux_pkg::*;
#(
	parameter int WIDTH = NUM_PINS
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] next_stage1;
	logic [WIDTH-1:0] next_q;

	if (WIDTH < 1) begin : g_check
		$error("input_sync needs WIDTH of at least 1");
	end

	always_comb begin
		next_stage1 = d;
		next_q = stage1;
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			stage1 <= {WIDTH{SYNC_RESET}};
			q <= {WIDTH{SYNC_RESET}};
		end else begin
			stage1 <= next_stage1;
			q <= next_q;
		end
	end
endmodule : input_sync

`default_nettype wire

// ### pin_routing_matrix.sv
// pin routing matrix for the 32-pin package: ownership, drive and input fan-out
`timescale 1ns/100ps
`default_nettype none

module pin_routing_matrix
	import pin_mux_pkg::*;
(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [NUM_PINS-1:0] pin_in,
	output logic [NUM_PINS-1:0] pin_out,
	output logic [NUM_PINS-1:0] pin_oe,
	input wire logic programming_mode_input,
	input wire logic [7:0] port0_pin_output,
	input wire logic [6:0] port1_pin_output,
	input wire logic [NUM_PINS-1:0] port_drive_enable,
	output logic [7:0] port0_pin_input,
	output logic [6:0] port1_pin_input,
	input wire cfg_t cfg,
	input wire periph_to_pins_t from_periph,
	output pins_to_periph_t to_periph,
	output logic [NUM_ANALOG-1:0] analog_select,
	output logic crystal_connect,
	output logic low_amp_clock_select
);
	// ****************************************
	// synchronised pin levels
	// ****************************************
	logic [NUM_PINS-1:0] pin_s;
	logic programming_mode_input_s;

	input_sync #(
		.WIDTH(NUM_PINS + 1)
	) u_sync (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.d({programming_mode_input, pin_in}),
		.q({programming_mode_input_s, pin_s})
	);

	// ****************************************
	// ownership
	// ****************************************
	function automatic owner_t pick_owner(input logic [NUM_PRI-1:0] r);
		owner_t o;
		o = OWN_PORT;
		if (r[PRI_TWO_WIRE]) o = OWN_TWO_WIRE;
		if (r[PRI_ANALOG]) o = OWN_ANALOG;
		if (r[PRI_PWM]) o = OWN_PWM;
		if (r[PRI_SLAVE]) o = OWN_SLAVE;
		if (r[PRI_MASTER]) o = OWN_MASTER;
		if (r[PRI_LF_OSC]) o = OWN_LF_OSC;
		return o;
	endfunction : pick_owner

	logic [NUM_PRI-1:0] req [NUM_PINS];
	owner_t owner [NUM_PINS];
	logic [NUM_PINS-1:0] port_out;
	logic slave_active;
	logic lf_crystal;
	logic lf_low_amp;
	logic lf_digital;
	logic uart_tx_eff;

	logic [NUM_PINS-1:0] next_pin_out;
	logic [NUM_PINS-1:0] next_pin_oe;
	logic [NUM_PINS-1:0] port_in;
	logic [NUM_PINS-1:0] next_port_in;
	pins_to_periph_t next_to_periph;
	logic [NUM_ANALOG-1:0] next_analog_select;
	logic next_crystal_connect;
	logic next_low_amp_clock_select;

	always_comb begin
		port_out = {port1_pin_output, port0_pin_output};
		slave_active = cfg.slave_enable | programming_mode_input_s;
		lf_crystal = cfg.low_freq_clock_source_select == LF_SEL_CRYSTAL;
		lf_low_amp = cfg.low_freq_clock_source_select == LF_SEL_LOW_AMP;
		lf_digital = cfg.low_freq_clock_source_select == LF_SEL_DIGITAL;
		for (int i = 0; i < NUM_PINS; i++) begin
			req[i] = '0;
			req[i][PRI_PORT] = 1'b1;
		end
		req[PIN_XTAL_A][PRI_LF_OSC] = lf_crystal;
		req[PIN_LF_CLOCK][PRI_LF_OSC] = lf_crystal | lf_low_amp | lf_digital;
		req[PIN_MASTER_IN][PRI_MASTER] = cfg.master_enable;
		req[PIN_MASTER_OUT][PRI_MASTER] = cfg.master_enable;
		req[PIN_MASTER_CLOCK][PRI_MASTER] = cfg.master_enable;
		req[PIN_CHIP_SELECT][PRI_SLAVE] = slave_active;
		req[PIN_SLAVE_OUT][PRI_SLAVE] = slave_active;
		req[PIN_SLAVE_IN][PRI_SLAVE] = slave_active;
		req[PIN_SCK_TW_DATA][PRI_SLAVE] = slave_active;
		req[PIN_PULSE_WIDTH_OUTPUT_1_TX][PRI_PWM] = cfg.pulse_width_output_1_enable;
		req[PIN_PULSE_WIDTH_OUTPUT_0][PRI_PWM] = cfg.pulse_width_output_0_enable;
		for (int k = 0; k < NUM_ANALOG; k++) begin
			req[k][PRI_ANALOG] = cfg.analog_enable[k];
		end
		req[PIN_SCK_TW_DATA][PRI_TWO_WIRE] = cfg.two_wire_enable;
		req[PIN_RX_TW_CLOCK][PRI_TWO_WIRE] = cfg.two_wire_enable;
		for (int i = 0; i < NUM_PINS; i++) begin
			owner[i] = pick_owner(req[i]);
		end
	end

	// ****************************************
	// pin drive
	// ****************************************
	always_comb begin
		uart_tx_eff = cfg.uart_tx_enable ? from_periph.uart_tx : 1'b1;
		for (int i = 0; i < NUM_PINS; i++) begin
			next_pin_oe[i] = (owner[i] == OWN_PORT) ? port_drive_enable[i] : 1'b0;
			next_pin_out[i] = (owner[i] == OWN_PORT) ? port_out[i] : 1'b0;
		end
		if (owner[PIN_PULSE_WIDTH_OUTPUT_1_TX] == OWN_PORT) begin
			next_pin_out[PIN_PULSE_WIDTH_OUTPUT_1_TX] = port_out[PIN_PULSE_WIDTH_OUTPUT_1_TX] & uart_tx_eff;
		end
		if (owner[PIN_MASTER_OUT] == OWN_MASTER) begin
			next_pin_oe[PIN_MASTER_OUT] = 1'b1;
			next_pin_out[PIN_MASTER_OUT] = from_periph.master_data_out;
		end
		if (owner[PIN_MASTER_CLOCK] == OWN_MASTER) begin
			next_pin_oe[PIN_MASTER_CLOCK] = 1'b1;
			next_pin_out[PIN_MASTER_CLOCK] = from_periph.master_serial_clock;
		end
		if (owner[PIN_SLAVE_OUT] == OWN_SLAVE) begin
			next_pin_oe[PIN_SLAVE_OUT] = !pin_s[PIN_CHIP_SELECT];
			next_pin_out[PIN_SLAVE_OUT] = programming_mode_input_s ? from_periph.programming_mode_input_port_data_out
				: from_periph.slave_data_out;
		end
		if (owner[PIN_PULSE_WIDTH_OUTPUT_1_TX] == OWN_PWM) begin
			next_pin_oe[PIN_PULSE_WIDTH_OUTPUT_1_TX] = 1'b1;
			next_pin_out[PIN_PULSE_WIDTH_OUTPUT_1_TX] = from_periph.pulse_width_output_1;
		end
		if (owner[PIN_PULSE_WIDTH_OUTPUT_0] == OWN_PWM) begin
			next_pin_oe[PIN_PULSE_WIDTH_OUTPUT_0] = 1'b1;
			next_pin_out[PIN_PULSE_WIDTH_OUTPUT_0] = from_periph.pulse_width_output_0;
		end
		// two-wire lines are open drain: drive only low
		if (owner[PIN_SCK_TW_DATA] == OWN_TWO_WIRE) begin
			next_pin_oe[PIN_SCK_TW_DATA] = from_periph.two_wire_data_drive_low;
		end
		if (owner[PIN_RX_TW_CLOCK] == OWN_TWO_WIRE) begin
			next_pin_oe[PIN_RX_TW_CLOCK] = from_periph.two_wire_clock_drive_low;
		end
	end

	// ****************************************
	// input fan-out
	// ****************************************
	always_comb begin
		next_port_in = pin_s;
		next_to_periph = TO_PERIPH_RESET;
		if (owner[PIN_MASTER_IN] == OWN_MASTER) begin
			next_to_periph.master_data_in = pin_s[PIN_MASTER_IN];
		end
		if (programming_mode_input_s) begin
			if (owner[PIN_CHIP_SELECT] == OWN_SLAVE) begin
				next_to_periph.programming_mode_input_port_chip_select_n = pin_s[PIN_CHIP_SELECT];
			end
			if (owner[PIN_SLAVE_IN] == OWN_SLAVE) begin
				next_to_periph.programming_mode_input_port_data_in = pin_s[PIN_SLAVE_IN];
			end
			if (owner[PIN_SCK_TW_DATA] == OWN_SLAVE) begin
				next_to_periph.programming_mode_input_port_serial_clock = pin_s[PIN_SCK_TW_DATA];
			end
		end else begin
			if (owner[PIN_CHIP_SELECT] == OWN_SLAVE) begin
				next_to_periph.slave_chip_select_n = pin_s[PIN_CHIP_SELECT];
			end
			if (owner[PIN_SLAVE_IN] == OWN_SLAVE) begin
				next_to_periph.slave_data_in = pin_s[PIN_SLAVE_IN];
			end
			if (owner[PIN_SCK_TW_DATA] == OWN_SLAVE) begin
				next_to_periph.slave_serial_clock = pin_s[PIN_SCK_TW_DATA];
			end
		end
		if (owner[PIN_SCK_TW_DATA] == OWN_TWO_WIRE) begin
			next_to_periph.two_wire_data_in = pin_s[PIN_SCK_TW_DATA];
		end
		if (owner[PIN_RX_TW_CLOCK] == OWN_TWO_WIRE) begin
			next_to_periph.two_wire_clock_in = pin_s[PIN_RX_TW_CLOCK];
		end
		// second listed inputs see the pin while it is not driven
		if (!next_pin_oe[PIN_SLAVE_IN]) next_to_periph.timer0_count_input = pin_s[PIN_SLAVE_IN];
		if (!next_pin_oe[PIN_SLAVE_OUT]) next_to_periph.timer1_count_input = pin_s[PIN_SLAVE_OUT];
		if (!next_pin_oe[PIN_PIN_INTERRUPT_INPUT_1]) next_to_periph.pin_interrupt_input_1 = pin_s[PIN_PIN_INTERRUPT_INPUT_1];
		if (!next_pin_oe[PIN_SCK_TW_DATA]) begin
			next_to_periph.pin_interrupt_input_0 = pin_s[PIN_SCK_TW_DATA];
		end
		if (!next_pin_oe[PIN_RX_TW_CLOCK]) next_to_periph.uart_rx = pin_s[PIN_RX_TW_CLOCK];
		if (lf_digital) next_to_periph.low_freq_clock = pin_s[PIN_LF_CLOCK];
		for (int k = 0; k < NUM_ANALOG; k++) begin
			next_analog_select[k] = owner[k] == OWN_ANALOG;
		end
		next_crystal_connect = lf_crystal;
		next_low_amp_clock_select = lf_low_amp;
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			pin_out <= PIN_OUT_RESET;
			pin_oe <= PIN_OE_RESET;
			port_in <= PORT_IN_RESET;
			to_periph <= TO_PERIPH_RESET;
			analog_select <= ANALOG_RESET;
			crystal_connect <= 1'b0;
			low_amp_clock_select <= 1'b0;
		end else begin
			pin_out <= next_pin_out;
			pin_oe <= next_pin_oe;
			port_in <= next_port_in;
			to_periph <= next_to_periph;
			analog_select <= next_analog_select;
			crystal_connect <= next_crystal_connect;
			low_amp_clock_select <= next_low_amp_clock_select;
		end
	end

	assign port0_pin_input = port_in[7:0];
	assign port1_pin_input = port_in[NUM_PINS-1:8];

	// ****************************************
	// checks
	// ****************************************
	property p_fanout;
		@(posedge clk_sys) disable iff (!resetn)
		!port_drive_enable[PIN_SLAVE_IN] |=>
			(to_periph.timer0_count_input == $past(pin_s[PIN_SLAVE_IN]))
			&& (port0_pin_input[PIN_SLAVE_IN] == $past(pin_s[PIN_SLAVE_IN]));
	endproperty
	a_fanout: assert property (p_fanout) else $error("timer0 and port input differ");

	property p_and_drive;
		@(posedge clk_sys) disable iff (!resetn)
		(!cfg.pulse_width_output_1_enable && !cfg.analog_enable[PIN_PULSE_WIDTH_OUTPUT_1_TX] && port_drive_enable[PIN_PULSE_WIDTH_OUTPUT_1_TX])
		|=> pin_oe[PIN_PULSE_WIDTH_OUTPUT_1_TX] && (pin_out[PIN_PULSE_WIDTH_OUTPUT_1_TX] ==
			($past(port0_pin_output[PIN_PULSE_WIDTH_OUTPUT_1_TX])
			& $past(!cfg.uart_tx_enable || from_periph.uart_tx)));
	endproperty
	a_and_drive: assert property (p_and_drive) else $error("shared pin is not the AND");

	property p_slave_out_cs;
		@(posedge clk_sys) disable iff (!resetn)
		(pin_oe[PIN_SLAVE_OUT] && $past(slave_active)) |-> !$past(pin_s[PIN_CHIP_SELECT]);
	endproperty
	a_slave_out_cs: assert property (p_slave_out_cs) else $error("slave out driven unselected");

	property p_pwm_over_analog;
		@(posedge clk_sys) disable iff (!resetn)
		(cfg.pulse_width_output_1_enable && cfg.analog_enable[PIN_PULSE_WIDTH_OUTPUT_1_TX]) |=>
			pin_oe[PIN_PULSE_WIDTH_OUTPUT_1_TX] && !analog_select[PIN_PULSE_WIDTH_OUTPUT_1_TX];
	endproperty
	a_pwm_over_analog: assert property (p_pwm_over_analog) else $error("pwm lost pin");

	property p_slave_over_two_wire;
		@(posedge clk_sys) disable iff (!resetn)
		(slave_active && cfg.two_wire_enable) |=>
			!pin_oe[PIN_SCK_TW_DATA] && to_periph.two_wire_data_in;
	endproperty
	a_slave_over_two_wire: assert property (p_slave_over_two_wire) else $error("two-wire won");

	property p_programming_mode_input_gate;
		@(posedge clk_sys) disable iff (!resetn)
		!programming_mode_input_s |=> to_periph.programming_mode_input_port_chip_select_n && !to_periph.programming_mode_input_port_serial_clock
			&& !to_periph.programming_mode_input_port_data_in;
	endproperty
	a_programming_mode_input_gate: assert property (p_programming_mode_input_gate) else $error("programming_mode_input port live outside programming_mode_input");

	property p_crystal;
		@(posedge clk_sys) disable iff (!resetn)
		(cfg.low_freq_clock_source_select == LF_SEL_CRYSTAL) |=>
			crystal_connect && !pin_oe[PIN_XTAL_A] && !pin_oe[PIN_LF_CLOCK];
	endproperty
	a_crystal: assert property (p_crystal) else $error("crystal pins not taken");

	property p_low_amp;
		@(posedge clk_sys) disable iff (!resetn)
		(cfg.low_freq_clock_source_select == LF_SEL_LOW_AMP) |=>
			low_amp_clock_select && !crystal_connect && !pin_oe[PIN_LF_CLOCK];
	endproperty
	a_low_amp: assert property (p_low_amp) else $error("low amplitude source not taken");

	property p_digital_clock;
		@(posedge clk_sys) disable iff (!resetn)
		(cfg.low_freq_clock_source_select == LF_SEL_DIGITAL) |=>
			to_periph.low_freq_clock == $past(pin_s[PIN_LF_CLOCK]);
	endproperty
	a_digital_clock: assert property (p_digital_clock) else $error("digital clock not routed");

	property p_idle_high;
		@(posedge clk_sys) disable iff (!resetn)
		(!cfg.uart_tx_enable && !cfg.pulse_width_output_1_enable && !cfg.analog_enable[PIN_PULSE_WIDTH_OUTPUT_1_TX]
			&& port_drive_enable[PIN_PULSE_WIDTH_OUTPUT_1_TX])
		|=> pin_out[PIN_PULSE_WIDTH_OUTPUT_1_TX] == $past(port0_pin_output[PIN_PULSE_WIDTH_OUTPUT_1_TX]);
	endproperty
	a_idle_high: assert property (p_idle_high) else $error("idle transmit pulled pin low");
endmodule : pin_routing_matrix

`default_nettype wire

// ### pin_side_model.sv
// far-side model of the package pins: external drivers and released lines
`timescale 1ns/100ps
`default_nettype none

module pin_side_model
	import pin_mux_pkg::*;
(
	input wire logic clk_sys,
	input wire logic [NUM_PINS-1:0] pin_out,
	input wire logic [NUM_PINS-1:0] pin_oe,
	input wire logic [NUM_PINS-1:0] ext_level,
	input wire logic [NUM_PINS-1:0] ext_drive,
	output logic [NUM_PINS-1:0] pin_in
);
	logic [NUM_PINS-1:0] last = '0;

	// two-wire lines have pull-ups; other released lines show the inverse of the last level
	always_comb begin
		for (int i = 0; i < NUM_PINS; i++) begin
			if (pin_oe[i])
				pin_in[i] = pin_out[i];
			else if (ext_drive[i])
				pin_in[i] = ext_level[i];
			else if (i == PIN_RX_TW_CLOCK || i == PIN_SCK_TW_DATA)
				pin_in[i] = 1'b1;
			else
				pin_in[i] = ~last[i];
		end
	end

	always @(posedge clk_sys) begin
		last <= pin_in;
	end
endmodule : pin_side_model

`default_nettype wire

// ### test_pin_routing_matrix.sv
// self-checking testbench of the pin routing matrix
`timescale 1ns/100ps
`default_nettype none

module test_pin_routing_matrix;
	import pin_mux_pkg::*;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic programming_mode_input = 1'b0;
	logic [7:0] port0_pin_output = 8'h00;
	logic [6:0] port1_pin_output = 7'h00;
	logic [NUM_PINS-1:0] port_drive_enable = 15'h0000;
	cfg_t cfg = '0;
	periph_to_pins_t from_periph = '0;
	logic [NUM_PINS-1:0] ext_level = 15'h7FFF;
	logic [NUM_PINS-1:0] ext_drive = 15'h7FFF;
	logic [NUM_PINS-1:0] pin_in;
	logic [NUM_PINS-1:0] pin_out;
	logic [NUM_PINS-1:0] pin_oe;
	logic [7:0] port0_pin_input;
	logic [6:0] port1_pin_input;
	pins_to_periph_t to_periph;
	logic [NUM_ANALOG-1:0] analog_select;
	logic crystal_connect;
	logic low_amp_clock_select;
	int n_mismatch = 0;
	int n_checks = 0;
	logic [7:0] lfsr = 8'h56;

	pin_routing_matrix u_dut (.clk_sys(clk_sys), .resetn(resetn), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe(pin_oe), .programming_mode_input(programming_mode_input),
		.port0_pin_output(port0_pin_output), .port1_pin_output(port1_pin_output),
		.port_drive_enable(port_drive_enable), .port0_pin_input(port0_pin_input),
		.port1_pin_input(port1_pin_input), .cfg(cfg), .from_periph(from_periph),
		.to_periph(to_periph), .analog_select(analog_select),
		.crystal_connect(crystal_connect), .low_amp_clock_select(low_amp_clock_select));

	pin_side_model u_pins (.clk_sys(clk_sys), .pin_out(pin_out), .pin_oe(pin_oe),
		.ext_level(ext_level), .ext_drive(ext_drive), .pin_in(pin_in));

	always #5 clk_sys = ~clk_sys;

	// ************************************************************
	// helpers
	// ************************************************************
	function automatic logic [7:0] next_rand(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : next_rand

	function automatic logic and_pin(input logic port, input logic tx, input logic tx_on);
		return port & (tx_on ? tx : 1'b1);
	endfunction : and_pin

	// pins P0.1/P0.0 taken by the low-frequency clock for a select code
	function automatic logic [1:0] lf_pins(input logic [2:0] sel);
		if (sel == LF_SEL_CRYSTAL)
			return 2'b11;
		if (sel == LF_SEL_LOW_AMP || sel == LF_SEL_DIGITAL)
			return 2'b10;
		return 2'b00;
	endfunction : lf_pins

	task automatic step(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : step

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : report_and_stop

	initial begin
		repeat (5000) @(posedge clk_sys);
		n_mismatch++;
		report_and_stop();
	end

	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		step(5);
		chk("oe_reset", 16'h0000, 16'(pin_oe));
		chk("periph_reset", 16'(TO_PERIPH_RESET), 16'(to_periph));
		step(1);
		resetn = 1'b1;
		// random levels on P0.7 and P1.0 fan out to both listed inputs
		cfg.slave_enable = 1'b1;
		for (int k = 0; k < 8; k++) begin
			lfsr = next_rand(lfsr);
			ext_level[7] = lfsr[0];
			ext_level[8] = lfsr[1];
			ext_level[6] = lfsr[2];
			ext_level[5] = lfsr[3];
			ext_level[4] = lfsr[4];
			port0_pin_output = lfsr;
			step(4);
			chk("timer0", 16'(lfsr[0]), 16'(to_periph.timer0_count_input));
			chk("slave_in", 16'(lfsr[0]), 16'(to_periph.slave_data_in));
			chk("port_in7", 16'(lfsr[0]), 16'(port0_pin_input[7]));
			chk("timer1", 16'(lfsr[1]), 16'(to_periph.timer1_count_input));
			chk("port_in8", 16'(lfsr[1]), 16'(port1_pin_input[0]));
			chk("intr1", 16'(lfsr[2]), 16'(to_periph.pin_interrupt_input_1));
			chk("slave_clk", 16'(lfsr[3]), 16'(to_periph.slave_serial_clock));
			chk("intr0", 16'(lfsr[3]), 16'(to_periph.pin_interrupt_input_0));
			chk("uart_rx", 16'(lfsr[4]), 16'(to_periph.uart_rx));
			chk("slave_cs_idle", 16'h0001, 16'(to_periph.slave_chip_select_n));
		end
		// slave data out driven only while chip select is low
		chk("miso_oe_idle", 16'h0000, 16'(pin_oe[8]));
		for (int k = 0; k < 4; k++) begin
			lfsr = next_rand(lfsr);
			from_periph.slave_data_out = lfsr[0];
			ext_level[9] = k[0];
			step(4);
			chk("miso_oe", 16'(!k[0]), 16'(pin_oe[8]));
			chk("slave_cs", 16'(k[0]), 16'(to_periph.slave_chip_select_n));
			if (!k[0]) begin
				chk("miso_out", 16'(lfsr[0]), 16'(pin_out[8]));
				chk("timer1_driven", 16'h0000, 16'(to_periph.timer1_count_input));
			end
		end
		// AND of port output and transmit on P0.3, unused transmit held high
		cfg.slave_enable = 1'b0;
		port_drive_enable[3] = 1'b1;
		for (int k = 0; k < 8; k++) begin
			{cfg.uart_tx_enable, port0_pin_output[3], from_periph.uart_tx} = 3'(k);
			step(2);
			chk("p03_oe", 16'h0001, 16'(pin_oe[3]));
			chk("p03_out", 16'(and_pin(k[1], k[0], k[2])), 16'(pin_out[3]));
		end
		// all functions compete
		cfg = '1;
		cfg.low_freq_clock_source_select = LF_SEL_CRYSTAL;
		port_drive_enable = 15'h7FFF;
		from_periph.pulse_width_output_0 = 1'b1;
		from_periph.pulse_width_output_1 = 1'b0;
		from_periph.master_data_out = 1'b1;
		from_periph.master_serial_clock = 1'b0;
		ext_level[9] = 1'b1;
		lfsr = next_rand(lfsr);
		ext_level[14] = lfsr[2];
		step(4);
		chk("analog_sel", 16'h0450, 16'(analog_select));
		chk("oe_all", 16'h380C, 16'(pin_oe));
		chk("pwm_out", 16'h0001, 16'(pin_out[3:2]));
		chk("master_out", 16'h0002, 16'(pin_out[13:12]));
		chk("master_in", 16'(lfsr[2]), 16'(to_periph.master_data_in));
		// programming port only in programming mode
		cfg = '0;
		port_drive_enable = 15'h0000;
		ext_level[9] = 1'b0;
		ext_level[7] = 1'b1;
		ext_level[5] = 1'b1;
		from_periph.programming_mode_input_port_data_out = 1'b1;
		step(5);
		chk("programming_mode_input_cs_off", 16'h0001, 16'(to_periph.programming_mode_input_port_chip_select_n));
		programming_mode_input = 1'b1;
		step(5);
		chk("programming_mode_input_cs_on", 16'h0000, 16'(to_periph.programming_mode_input_port_chip_select_n));
		chk("programming_mode_input_out", 16'h0003, 16'({pin_oe[8], pin_out[8]}));
		chk("programming_mode_input_din", 16'h0001, 16'(to_periph.programming_mode_input_port_data_in));
		chk("programming_mode_input_clk", 16'h0001, 16'(to_periph.programming_mode_input_port_serial_clock));
		chk("slave_in_idle", 16'h0000, 16'(to_periph.slave_data_in));
		programming_mode_input = 1'b0;
		// every low-frequency select code
		port_drive_enable = 15'h7FFF;
		for (int k = 0; k < 8; k++) begin
			lfsr = next_rand(lfsr);
			ext_level[1] = lfsr[0];
			cfg.low_freq_clock_source_select = 3'(k);
			step(4);
			chk("lf_oe", {14'h0000, ~lf_pins(3'(k))}, 16'(pin_oe[1:0]));
			chk("crystal", 16'(k == 0), 16'(crystal_connect));
			chk("low_amp", 16'(k == 3), 16'(low_amp_clock_select));
			chk("lf_clk", 16'(k == 4 && lfsr[0]), 16'(to_periph.low_freq_clock));
		end
		// two-wire lines released to their pull-ups, driven low on request
		cfg = '0;
		cfg.two_wire_enable = 1'b1;
		port_drive_enable = 15'h0000;
		ext_drive[5:4] = 2'b00;
		for (int k = 0; k < 4; k++) begin
			{from_periph.two_wire_clock_drive_low, from_periph.two_wire_data_drive_low} = 2'(k);
			step(5);
			chk("tw_oe", 16'(k), 16'({pin_oe[4], pin_oe[5]}));
			chk("tw_out", 16'h0000, 16'(pin_out[5:4]));
			chk("tw_data_in", 16'(!k[0]), 16'(to_periph.two_wire_data_in));
			chk("tw_clock_in", 16'(!k[1]), 16'(to_periph.two_wire_clock_in));
			chk("tw_intr0", 16'(!k[0]), 16'(to_periph.pin_interrupt_input_0));
			chk("tw_uart_rx", 16'h0001, 16'(to_periph.uart_rx));
		end
		report_and_stop();
	end
endmodule : test_pin_routing_matrix

`default_nettype wire
